// ==== rtl/sflash_pkg.sv ====
// Shared constants, types and opcode map for the serial flash front end
// What this block does
// - Outgoing serial bits change on the falling serial clock edge.
// - Command, address and data bits are sampled on rising serial clock edges.
// - Select high means deselected and the data output is not driven.
// - Deselected device drops to standby unless an internal cycle still runs.
// - Select low selects the device and makes it active.
// - After power-up an instruction starts only at a falling select edge or with select low as reset ends.
// - Reset pin high runs normally; low with nothing running enters reset state.
// - In reset state every output of the serial side is undriven.
// - Reset pin asserted during a write, program or erase cycle leaves it running.
// - Write protect low makes the first 256 pages read-only.
// - Write protect high treats the first 256 pages like all others.
// - Clock idle low or idle high are both accepted, same edges used.
// - Array decodes as 8 sectors of 256 pages of 256 bytes.
// - Page rewrite erases the addressed page, then programs it.
// - Erase works per page or per whole sector.
// - Modification needs the enable latch set beforehand, else refused.
// - Modify instructions count only with a whole number of bytes clocked.
// - Status byte holds busy in bit 0, enable latch in bit 1, rest zero.
package sflash_pkg;
	// Opcodes, values are arbitrary
	localparam logic [7:0] OP_SET_LATCH   = 8'h06;
	localparam logic [7:0] OP_CLR_LATCH   = 8'h04;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_REWRITE     = 8'h0A;
	localparam logic [7:0] OP_PROGRAM     = 8'h02;
	localparam logic [7:0] OP_PAGE_ERASE  = 8'hDB;
	localparam logic [7:0] OP_SECT_ERASE  = 8'hD8;
	// APB byte offsets
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_OPADDR  = 8'h08;
	localparam logic [7:0] REG_FIFO    = 8'h0C;
	localparam logic [7:0] REG_DATACNT = 8'h10;
	// Field positions
	localparam int CTRL_DONE_BIT   = 0;
	localparam int CTRL_CLROVR_BIT = 1;
	localparam int SR_BUSY_BIT     = 0;
	localparam int SR_LATCH_BIT    = 1;
	localparam int ST_PHASE_LSB    = 8;
	localparam int ST_RESET_BIT    = 10;
	localparam int ST_ACTIVE_BIT   = 11;
	localparam int ST_KIND_LSB     = 12;
	localparam int ST_OVR_BIT      = 15;
	localparam int FIFO_VALID_BIT  = 8;
	// Array geometry: 19-bit byte address, page in [18:8], sector in [18:16]
	localparam int         ADDR_W      = 19;
	localparam int         PAGE_LSB    = 8;
	localparam logic [10:0] PROT_PAGES = 11'h100;
	localparam logic [8:0] PAGE_BYTES  = 9'h100;
	localparam int         FIFO_W      = 8;
	localparam int         FIFO_DEPTH  = 4;
	// Pin reset image: sclk, cs_n, mosi, reset_n, wp_n
	localparam logic [4:0] PINS_RST = 5'h0B;

	typedef enum logic [2:0] {KIND_NONE, KIND_REWRITE, KIND_PROGRAM, KIND_PAGE_ERASE,
		KIND_SECT_ERASE} op_kind_t;
	typedef enum logic [1:0] {PH_IDLE, PH_ERASE, PH_PROG} phase_t;
	typedef enum logic [2:0] {D_CMD, D_ADDR, D_DATA, D_TX, D_SKIP} dec_t;

	typedef struct packed {
		op_kind_t           kind;
		logic [ADDR_W-1:0] addr;
	} op_rec_t;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
		logic reset_n;
		logic wp_n;
	} pins_t;
endpackage

// ==== rtl/sflash_front.sv ====
// Serial flash front end: pin sampling, instruction decode, APB back-end port
`timescale 1ns/1ps

module sflash_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	input  wire logic         clk_sys_i,
	input  wire logic         sys_rst_i,
	input  wire logic         flush_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_r [DEPTH];
	logic [AW:0]  wr_ptr_r;
	logic [AW:0]  rd_ptr_r;
	logic         push;
	logic         pop;

	// Extra pointer bit tells full from empty
	assign out_valid_o = wr_ptr_r != rd_ptr_r;
	assign in_ready_o  = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_data_o  = mem_r[rd_ptr_r[AW-1:0]];

	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || flush_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule

module sflash_front
	import sflash_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        mosi_i,
	input  wire logic        reset_n_i,
	input  wire logic        wp_n_i,
	output logic             sdo_o,
	output logic             sdo_oe_o,
	output logic             power_active_o,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o
);
	pins_t             pin_meta_r;
	pins_t             pin_sync_r;
	pins_t             pin_prev_r;
	logic              sclk_rise, sclk_fall, cs_fall, cs_rise, selected;
	logic              armed_r, frame_r, in_reset_r, latch_r, ovr_r;
	dec_t              dec_r;
	logic [2:0]        bit_cnt_r, tx_cnt_r;
	logic [1:0]        addr_cnt_r;
	logic [7:0]        shift_in_r, opcode_r, tx_shift_r, byte_in, status_byte;
	logic [ADDR_W-1:0] addr_r;
	logic [8:0]        data_cnt_r;
	logic              byte_done, commit, aligned, addr_ok, is_mod, prot, start_op;
	op_kind_t          kind_in;
	op_rec_t           op_r;
	phase_t            phase_r;
	logic              busy, done_pulse, op_finish;
	logic              access, fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
	logic              fifo_flush;
	logic [7:0]        fifo_out_data;
	logic [31:0]       status_word;

	// Every pin crosses two flops; pin_sync_r and its delayed copy pin_prev_r feed logic
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			pin_meta_r <= PINS_RST;
			pin_sync_r <= PINS_RST;
			pin_prev_r <= PINS_RST;
		end else begin
			pin_meta_r <= {sclk_i, cs_n_i, mosi_i, reset_n_i, wp_n_i};
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	// Edges found on the synchronised copy; clock idle level never matters
	assign sclk_rise = pin_sync_r.sclk & ~pin_prev_r.sclk;
	assign sclk_fall = ~pin_sync_r.sclk & pin_prev_r.sclk;
	assign cs_fall   = ~pin_sync_r.cs_n & pin_prev_r.cs_n;
	assign cs_rise   = pin_sync_r.cs_n & ~pin_prev_r.cs_n;
	assign selected  = ~pin_sync_r.cs_n;
	assign busy      = phase_r != PH_IDLE;
	assign status_byte = {6'h00, latch_r, busy};
	assign byte_in   = {shift_in_r[6:0], pin_sync_r.mosi};
	assign byte_done = frame_r & sclk_rise & (bit_cnt_r == 3'h7);

	// Opcode classification
	always_comb begin
		case (opcode_r)
			OP_REWRITE:    kind_in = KIND_REWRITE;
			OP_PROGRAM:    kind_in = KIND_PROGRAM;
			OP_PAGE_ERASE: kind_in = KIND_PAGE_ERASE;
			OP_SECT_ERASE: kind_in = KIND_SECT_ERASE;
			default:       kind_in = KIND_NONE;
		endcase
	end
	assign is_mod = kind_in != KIND_NONE;

	// Reset state only entered with nothing running; a running cycle goes on
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			in_reset_r <= 1'b0;
		end else begin
			in_reset_r <= ~pin_sync_r.reset_n & (in_reset_r | ~busy);
		end
	end

	// A select falling edge is needed first; cs low at power-up counts as one, as the pin reset image holds cs_n high
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			armed_r <= 1'b0;
			frame_r <= 1'b0;
		end else begin
			if (pin_sync_r.cs_n) begin
				armed_r <= 1'b1;
			end
			if (cs_rise || in_reset_r) begin
				frame_r <= 1'b0;
			end else if (cs_fall && armed_r) begin
				frame_r <= 1'b1;
			end
		end
	end

	// Receive shifter and decoder, sampled on rising serial clock
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			dec_r      <= D_CMD;
			bit_cnt_r  <= 3'h0;
			addr_cnt_r <= 2'h0;
			shift_in_r <= 8'h00;
			opcode_r   <= 8'h00;
			addr_r     <= '0;
			data_cnt_r <= 9'h000;
		end else if (cs_fall) begin
			dec_r      <= D_CMD;
			bit_cnt_r  <= 3'h0;
			addr_cnt_r <= 2'h0;
			data_cnt_r <= 9'h000;
		end else if (frame_r && sclk_rise) begin
			bit_cnt_r  <= bit_cnt_r + 3'h1;
			shift_in_r <= byte_in;
			if (bit_cnt_r == 3'h7) begin
				case (dec_r)
					D_CMD: begin
						opcode_r <= byte_in;
						if (byte_in == OP_READ_STATUS) begin
							dec_r <= D_TX;
						end else if ((byte_in == OP_REWRITE || byte_in == OP_PROGRAM ||
							byte_in == OP_PAGE_ERASE || byte_in == OP_SECT_ERASE) && !busy) begin
							dec_r <= D_ADDR;
						end else begin
							dec_r <= D_SKIP;
						end
					end
					D_ADDR: begin
						addr_r     <= {addr_r[ADDR_W-9:0], byte_in};
						addr_cnt_r <= addr_cnt_r + 2'h1;
						if (addr_cnt_r == 2'h2) begin
							dec_r <= (kind_in == KIND_REWRITE || kind_in == KIND_PROGRAM)
								? D_DATA : D_SKIP;
						end
					end
					D_DATA: begin
						if (data_cnt_r != PAGE_BYTES) begin
							data_cnt_r <= data_cnt_r + 9'h001;
						end
					end
					D_TX, D_SKIP: begin
						dec_r <= dec_r;
					end
					default: begin
						dec_r <= D_SKIP;
					end
				endcase
			end
		end
	end

	// Data bytes go to the buffer; when it is full the byte is dropped and flagged
	assign fifo_in_valid = byte_done & (dec_r == D_DATA);
	assign fifo_flush    = byte_done & (dec_r == D_ADDR) & (addr_cnt_r == 2'h0);

	sflash_fifo #(
		.W     (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.sys_rst_i   (sys_rst_i),
		.flush_i     (fifo_flush),
		.in_valid_i  (fifo_in_valid),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (byte_in),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_out_data)
	);

	// Transmit shifter: status byte repeats while select stays low
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			tx_shift_r <= 8'h00;
			tx_cnt_r   <= 3'h0;
			sdo_o      <= 1'b0;
		end else if (byte_done && dec_r == D_CMD) begin
			tx_shift_r <= status_byte;
			tx_cnt_r   <= 3'h0;
		end else if (frame_r && sclk_fall && dec_r == D_TX) begin
			sdo_o    <= tx_shift_r[7];
			tx_cnt_r <= tx_cnt_r + 3'h1;
			tx_shift_r <= (tx_cnt_r == 3'h7) ? status_byte : {tx_shift_r[6:0], 1'b0};
		end
	end

	// Output driven only while selected, transmitting and out of reset
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			sdo_oe_o <= 1'b0;
		end else begin
			sdo_oe_o <= selected & frame_r & (dec_r == D_TX) & ~in_reset_r;
		end
	end

	// Active while selected or while an internal cycle runs
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			power_active_o <= 1'b0;
		end else begin
			power_active_o <= selected | busy;
		end
	end

	// End-of-frame checks; page index is addr[18:8], sector addr[18:16]
	assign commit  = frame_r & cs_rise;
	assign aligned = (bit_cnt_r == 3'h0) & (dec_r != D_CMD);
	assign addr_ok = (dec_r == D_DATA) ? (data_cnt_r != 9'h000) : (addr_cnt_r == 2'h3);
	assign prot    = ~pin_sync_r.wp_n & (addr_r[ADDR_W-1:PAGE_LSB] < PROT_PAGES);
	assign start_op = commit & is_mod & aligned & addr_ok & latch_r & ~busy & ~prot;
	assign op_finish = done_pulse & busy & ~(phase_r == PH_ERASE && op_r.kind == KIND_REWRITE);

	// Phase sequencer, stepped by the back end; reset pin does not touch it
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			phase_r <= PH_IDLE;
			op_r    <= '{kind: KIND_NONE, addr: '0};
		end else if (start_op) begin
			op_r    <= '{kind: kind_in, addr: addr_r};
			phase_r <= (kind_in == KIND_PROGRAM) ? PH_PROG : PH_ERASE;
		end else if (done_pulse) begin
			case (phase_r)
				PH_ERASE: phase_r <= (op_r.kind == KIND_REWRITE) ? PH_PROG : PH_IDLE;
				PH_PROG:  phase_r <= PH_IDLE;
				default:  phase_r <= PH_IDLE;
			endcase
		end
	end

	// Enable latch: cleared by reset state and by completion of a modify cycle
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			latch_r <= 1'b0;
		end else if (in_reset_r || op_finish) begin
			latch_r <= 1'b0;
		end else if (commit && aligned && !busy && opcode_r == OP_SET_LATCH) begin
			latch_r <= 1'b1;
		end else if (commit && aligned && !busy && opcode_r == OP_CLR_LATCH) begin
			latch_r <= 1'b0;
		end
	end

	// APB: one wait state, pready pulses for one cycle per transfer
	assign access     = psel_i & penable_i & ~pready_o;
	assign done_pulse = access & pwrite_i & (paddr_i == REG_CTRL) & pwdata_i[CTRL_DONE_BIT];
	assign fifo_pop   = access & ~pwrite_i & (paddr_i == REG_FIFO);
	assign status_word = {16'h0000, ovr_r, op_r.kind, power_active_o, in_reset_r, phase_r,
		status_byte};

	// Overrun sticky; a new overrun beats a clear in the same cycle
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ovr_r <= 1'b0;
		end else if (fifo_in_valid && !fifo_in_ready) begin
			ovr_r <= 1'b1;
		end else if (access && pwrite_i && paddr_i == REG_CTRL && pwdata_i[CTRL_CLROVR_BIT]) begin
			ovr_r <= 1'b0;
		end
	end

	// Read data and error flag registered with pready
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h00000000;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= access;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
			if (access) begin
				case (paddr_i)
					REG_CTRL:    prdata_o <= 32'h00000000;
					REG_STATUS:  prdata_o <= status_word;
					REG_OPADDR:  prdata_o <= {13'h0000, op_r.addr};
					REG_FIFO:    prdata_o <= {23'h000000, fifo_out_valid, fifo_out_data};
					REG_DATACNT: prdata_o <= {23'h000000, data_cnt_r};
					default:     pslverr_o <= 1'b1;
				endcase
			end
		end
	end

	// Checks on the decoder, output driver and sequencer
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence rewrite_start_s;
		start_op && kind_in == KIND_REWRITE;
	endsequence
	sequence erase_step_s;
		done_pulse && phase_r == PH_ERASE && op_r.kind == KIND_REWRITE;
	endsequence

	sdo_hiz_a: assert property (pin_sync_r.cs_n |=> !sdo_oe_o)
		else $error("data output driven while deselected");
	sdo_fall_a: assert property ($changed(sdo_o) |-> $past(sclk_fall))
		else $error("data output changed without falling clock");
	sample_rise_a: assert property ($changed(bit_cnt_r) |-> $past(sclk_rise) || $past(cs_fall))
		else $error("bit counter moved without rising clock");
	standby_a: assert property (!selected && !busy |=> !power_active_o)
		else $error("not in standby while idle and deselected");
	active_a: assert property (selected |=> power_active_o)
		else $error("not active while selected");
	frame_arm_a: assert property ($rose(frame_r) |-> $past(cs_fall) && $past(armed_r))
		else $error("frame opened without select falling edge");
	reset_enter_a: assert property (!pin_sync_r.reset_n && !busy |=> in_reset_r)
		else $error("reset state not entered");
	reset_hiz_a: assert property (in_reset_r |=> !sdo_oe_o)
		else $error("output driven in reset state");
	busy_keep_a: assert property (busy && !done_pulse |=> busy)
		else $error("internal cycle disturbed");
	protect_a: assert property (commit && prot |=> phase_r == $past(phase_r))
		else $error("protected page modified");
	rewrite_erase_a: assert property (rewrite_start_s |=> phase_r == PH_ERASE)
		else $error("rewrite did not start with erase");
	rewrite_prog_a: assert property (erase_step_s |=> phase_r == PH_PROG)
		else $error("rewrite did not program after erase");
	align_a: assert property (commit && bit_cnt_r != 3'h0 |=> !$rose(busy))
		else $error("unaligned modify accepted");
	latch_need_a: assert property (commit && !latch_r |=> !$rose(busy))
		else $error("modify accepted with latch clear");
endmodule

// ==== sim/spi_master_model.sv ====
// Behavioural serial bus master that clocks frames into the flash front end
`timescale 1ns/1ps

module spi_master_model (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i
);
	// Select idles high so the first frame opens with a falling edge
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// One frame of nbits; the link clock only toggles while selected, except to take a new mode's idle level before select falls
	task automatic xfer(input logic [95:0] tx, input int nbits, input logic cpol,
		output logic [95:0] rx, output logic oe_seen);
		rx = '0;
		oe_seen = 1'b0;
		sclk_o = cpol; // Idle level per mode
		#80 cs_n_o = 1'b0; // Falling select opens every frame
		for (int i = 0; i < nbits; i++) begin
			sclk_o = 1'b0;
			mosi_o = tx[95 - i]; // Top bit first
			#80 sclk_o = 1'b1;
			// Sample late in the high phase, the slave output lags by a few clocks
			#80 rx = {rx[94:0], sdo_oe_i ? sdo_i : ~sdo_i}; // Undriven line reads as the inverted data bit
			oe_seen = oe_seen | sdo_oe_i;
		end
		sclk_o = cpol;
		#80 cs_n_o = 1'b1;
		mosi_o = ~mosi_o; // Released line must not look like held data
		#160;
	endtask
endmodule

// ==== sim/sflash_front_tb.sv ====
// Self-checking bench for the serial flash front end and its APB port
`timescale 1ns/1ps

module sflash_front_tb
	import sflash_pkg::*;
;
	logic        clk_sys_i;
	logic        sys_rst_i;
	logic        sclk, cs_n, mosi, reset_n, wp_n;
	logic        sdo, sdo_oe, pwr_act;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [95:0] rx;
	logic        oe_seen, e;
	logic [18:0] addr;
	logic [7:0]  dat;
	int          n_mismatch = 0;
	int          n_compared = 0;
	logic [7:0]  op_tab [4] = '{OP_REWRITE, OP_PROGRAM, OP_PAGE_ERASE, OP_SECT_ERASE};
	logic [1:0]  ph_tab [4] = '{2'h1, 2'h2, 2'h1, 2'h1};

	sflash_front dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk),
		.cs_n_i(cs_n), .mosi_i(mosi), .reset_n_i(reset_n), .wp_n_i(wp_n), .sdo_o(sdo),
		.sdo_oe_o(sdo_oe), .power_active_o(pwr_act), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr));
	spi_master_model spi_u (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .sdo_i(sdo),
		.sdo_oe_i(sdo_oe));

	// Status word from {latch,busy}, phase, {active,reset}, kind, overrun
	function automatic logic [31:0] st_exp(input logic [1:0] bl, input logic [1:0] ph,
		input logic [1:0] ra, input logic [2:0] kind, input logic ovr);
		return {16'h0000, ovr, kind, ra, ph, 6'h00, bl};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer; waits on pready, never on a fixed count
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys_i);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) n_mismatch++;
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Extra clocks let the select rise cross the synchroniser
	task automatic frame(input logic [95:0] tx, input int nbits, input logic cpol);
		spi_u.xfer(tx, nbits, cpol, rx, oe_seen);
		repeat (4) @(posedge clk_sys_i);
	endtask

	task automatic latch_on();
		frame({OP_SET_LATCH, 88'h0}, 8, 1'b0);
	endtask

	// Software stands in for the back end and steps every phase to the end
	task automatic finish_op();
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, REG_STATUS, 32'h0);
			if (q[SR_BUSY_BIT] === 1'b1) apb(1'b1, REG_CTRL, 32'h1);
		end
		apb(1'b0, REG_STATUS, 32'h0);
	endtask

	task automatic wrap_up();
		$display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	// Guards against a hang far beyond the expected run of about 100 us
	initial begin
		#1500000;
		n_mismatch++;
		wrap_up();
	end

	initial begin
		sys_rst_i = 1'b1;
		reset_n = 1'b1;
		wp_n = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		void'($urandom(32'hD949));
		repeat (4) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		// Idle state, read-only status ignores writes, random unmapped places fail
		apb(1'b1, REG_STATUS, 32'hFFFF);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(q, 32'h0); // Standby after reset
		chk({31'h0, e}, 32'h0); // Mapped read raises no error
		chk({31'h0, sdo_oe}, 32'h0); // Deselected output off
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, {6'($urandom_range(63, 5)), 2'b00}, 32'h0);
			chk({31'h0, e}, 32'h1);
		end
		// Status over the link in both clock modes, two bytes per frame
		latch_on();
		for (int m = 0; m < 2; m++) begin
			fork
				frame({OP_READ_STATUS, 88'h0}, 24, m[0]);
				#1010 chk({31'h0, pwr_act}, 32'h1); // Selected is active
			join
			chk({24'h0, rx[15:8]}, 32'h2); // Bit order and fall launch
			chk({24'h0, rx[7:0]}, 32'h2); // Status byte layout
			chk({30'h0, sdo_oe, pwr_act}, 32'h0); // Deselect idles the pins
		end
		// Every modify kind: protected boundary, write protect off, random sectors
		for (int i = 0; i < 4; i++) begin
			addr = (i == 0) ? 19'h10000 : (i == 1) ? {3'h0, 16'($urandom)} :
				{3'($urandom_range(7, 1)), 16'($urandom)};
			dat = 8'($urandom);
			@(posedge clk_sys_i) wp_n <= (i == 1);
			latch_on();
			frame({op_tab[i], 5'h00, addr, dat, 56'h0}, (i < 2) ? 40 : 32, 1'b0);
			apb(1'b0, REG_STATUS, 32'h0);
			chk(q, st_exp(2'h3, ph_tab[i], 2'h2, 3'(i + 1), 1'b0)); // Kinds
			apb(1'b0, REG_OPADDR, 32'h0);
			chk(q, {13'h0, addr}); // Page and sector decode
			if (i < 2) begin
				apb(1'b0, REG_FIFO, 32'h0);
				chk(q, {23'h0, 1'b1, dat}); // Data sampled on rises
			end
			apb(1'b1, REG_CTRL, 32'h1);
			apb(1'b0, REG_STATUS, 32'h0);
			if (i == 0) chk(q, st_exp(2'h3, 2'h2, 2'h2, 3'h1, 1'b0));
			finish_op();
			// The kind field keeps the last accepted operation after it ends
			chk(q, st_exp(2'h0, 2'h0, 2'h0, 3'(i + 1), 1'b0));
		end
		// Refusals: protected page, ragged bit count, latch clear
		latch_on();
		frame({OP_REWRITE, 24'h00FF00, 8'h5A, 56'h0}, 40, 1'b0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(q, st_exp(2'h2, 2'h0, 2'h0, 3'h4, 1'b0)); // Write protect low
		frame({OP_PAGE_ERASE, 24'h012C00, 64'h0}, 33, 1'b0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(q, st_exp(2'h2, 2'h0, 2'h0, 3'h4, 1'b0)); // Not whole bytes
		frame({OP_CLR_LATCH, 88'h0}, 8, 1'b0);
		frame({OP_PAGE_ERASE, 24'h012C00, 64'h0}, 32, 1'b0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(q, st_exp(2'h0, 2'h0, 2'h0, 3'h4, 1'b0)); // Latch clear
		// Six data bytes into a four deep buffer that nobody drains
		latch_on();
		frame({OP_PROGRAM, 24'h020000, 48'($urandom), 16'h0}, 80, 1'b0);
		apb(1'b0, REG_DATACNT, 32'h0);
		chk(q, 32'h6); // Byte count
		apb(1'b0, REG_STATUS, 32'h0);
		chk(q, st_exp(2'h3, 2'h2, 2'h2, 3'h2, 1'b1));
		apb(1'b1, REG_CTRL, 32'h2);
		finish_op();
		chk(q, st_exp(2'h0, 2'h0, 2'h0, 3'h2, 1'b0)); // Overrun cleared
		// Reset pin while busy, then reset state once idle
		latch_on();
		frame({OP_SECT_ERASE, 24'h050000, 64'h0}, 32, 1'b0);
		// A second modify while busy must be ignored
		frame({OP_PAGE_ERASE, 24'h012C00, 64'h0}, 32, 1'b0);
		@(posedge clk_sys_i) reset_n <= 1'b0;
		repeat (10) @(posedge clk_sys_i);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(q, st_exp(2'h3, 2'h1, 2'h2, 3'h4, 1'b0)); // Cycle survives
		finish_op();
		repeat (10) @(posedge clk_sys_i);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(q, st_exp(2'h0, 2'h0, 2'h1, 3'h4, 1'b0)); // Reset state
		frame({OP_READ_STATUS, 88'h0}, 16, 1'b0);
		chk({31'h0, oe_seen}, 32'h0); // Outputs stay off
		@(posedge clk_sys_i) reset_n <= 1'b1;
		repeat (10) @(posedge clk_sys_i);
		wrap_up();
	end
endmodule
